// File: ascs_card_model.sv
// behavioural card: command, data bytes, crc status and stop timing in card clocks
`timescale 1ns/100ps
module ascs_card_model (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CCLK_OUT,
    input  wire logic        CMD_START,
    input  wire logic        STOP_LOAD,
    input  wire logic        DATA_HOLD,
    input  wire logic [15:0] total,
    input  wire logic [15:0] blk,
    input  wire logic        wr,
    input  wire logic        stream,
    output logic             CCLK_FB,
    output logic             CMD_IDLE,
    output logic             CARD_IDLE,
    output logic             BYTE_DONE,
    output logic             CRC_DONE,
    output logic             STOP_END,
    output logic             DATA_DONE
);
    logic        cq;
    logic        act;
    logic [5:0]  cmd_n;
    logic [5:0]  stop_n;
    logic [2:0]  bit_n;
    logic [2:0]  crc_n;
    logic [15:0] sent;
    assign CCLK_FB   = CCLK_OUT;
    assign CMD_IDLE  = (cmd_n == 6'h00) && (stop_n == 6'h00);
    assign CARD_IDLE = ~act && CMD_IDLE;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cq        <= 1'b0;
            act       <= 1'b0;
            cmd_n     <= 6'h00;
            stop_n    <= 6'h00;
            bit_n     <= 3'h0;
            crc_n     <= 3'h0;
            sent      <= 16'h0000;
            BYTE_DONE <= 1'b0;
            CRC_DONE  <= 1'b0;
            STOP_END  <= 1'b0;
            DATA_DONE <= 1'b0;
        end else begin
            cq        <= CCLK_OUT;
            BYTE_DONE <= 1'b0;
            CRC_DONE  <= 1'b0;
            STOP_END  <= 1'b0;
            DATA_DONE <= 1'b0;
            if (CMD_START) begin
                cmd_n <= 6'h10;
                act   <= 1'b1;
                sent  <= 16'h0000;
                bit_n <= 3'h0;
            end
            if (STOP_LOAD) begin
                stop_n <= 6'h30;
            end
            // counters and data bits on the card advance only on card clock rises; command and stop loads act on any CLK
            if (CCLK_OUT && !cq) begin
                if (cmd_n != 6'h00) begin
                    cmd_n <= cmd_n - 6'h01;
                end
                if (stop_n != 6'h00) begin
                    stop_n <= stop_n - 6'h01;
                end
                if (stop_n == 6'h01) begin
                    STOP_END <= 1'b1;
                    if (stream) begin
                        act <= 1'b0;
                    end
                end
                if (crc_n != 3'h0) begin
                    crc_n <= crc_n - 3'h1;
                    if (crc_n == 3'h1) begin
                        CRC_DONE <= 1'b1;
                        if (sent == total) begin
                            act       <= 1'b0;
                            DATA_DONE <= 1'b1;
                        end
                    end
                end else if (act && cmd_n == 6'h00 && !DATA_HOLD) begin
                    bit_n <= bit_n + 3'h1;
                    if (bit_n == 3'h7) begin
                        BYTE_DONE <= 1'b1;
                        sent      <= sent + 16'h0001;
                        if (!stream && wr && (sent + 16'h0001) % blk == 16'h0000) begin
                            crc_n <= 3'h4;
                        end
                        if (!stream && !wr && sent + 16'h0001 == total) begin
                            act       <= 1'b0;
                            DATA_DONE <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule : ascs_card_model

// File: ascs_clkdiv.sv
// card clock divider with enable; divider setting taken only while stopped
`timescale 1ns/100ps
module ascs_clkdiv #(
    parameter int DIV_W = 8
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic             en,
    input  wire logic [DIV_W-1:0] div,
    output logic                  cclk
);
    typedef struct packed {
        logic             en_q;
        logic [DIV_W-1:0] n;
        logic [DIV_W-1:0] cnt;
        logic             ph;
    } ascs_div_t;

    ascs_div_t r;
    ascs_div_t next_r;

    initial begin
        if (DIV_W < 1 || DIV_W > 16) $error("ascs_clkdiv: DIV_W out of range");
    end

    always_comb begin
        next_r = r;
        next_r.en_q = en;
        if (!en) begin
            next_r.n   = div;
            next_r.cnt = '0;
            next_r.ph  = 1'b0;
        end else if (r.n != '0) begin
            if (r.cnt == r.n - DIV_W'(1)) begin
                next_r.cnt = '0;
                next_r.ph  = ~r.ph;
            end else begin
                next_r.cnt = r.cnt + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // bypass passes the source clock, gated by the registered enable
    assign cclk = (r.n == '0) ? (CLK & r.en_q) : r.ph;

    div_stopped_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !en |=> (r.ph == 1'b0 && r.cnt == '0 && r.n == $past(div)))
        else $error("divider not parked while clock off");
    div_half_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (en && r.en_q && r.n != '0 && r.cnt != r.n - DIV_W'(1)) |=> $stable(r.ph))
        else $error("divider phase toggled early");
endmodule : ascs_clkdiv

// File: ascs_pkg.sv
// types shared by the stop/clock block
package ascs_pkg;
    typedef enum logic [2:0] {
        ASCS_IDLE = 3'b001,
        ASCS_RUN  = 3'b010,
        ASCS_TAIL = 3'b100
    } ascs_phase_t;

    typedef enum logic [1:0] {
        ASCS_W1 = 2'h0,
        ASCS_W4 = 2'h1,
        ASCS_W8 = 2'h2
    } ascs_width_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ascs_apb_req_t;

    typedef struct packed {
        logic full;
        logic empty;
        logic cmd_idle;
        logic card_idle;
        logic byte_done;
        logic crc_done;
        logic stop_end;
        logic data_done;
    } ascs_path_t;
endpackage : ascs_pkg

// File: ascs_regs.svh
// register offsets, field positions, reset values and timing counts of the stop/clock block
`ifndef ASCS_REGS_SVH
`define ASCS_REGS_SVH
`define ASCS_OFS_CLK_CTRL  8'h00
`define ASCS_OFS_XFER_CFG  8'h04
`define ASCS_OFS_BYTE_CNT  8'h08
`define ASCS_OFS_CMD       8'h0C
`define ASCS_OFS_STATUS    8'h10
`define ASCS_CLK_ON_BIT    0
`define ASCS_LOW_PWR_BIT   1
`define ASCS_DIV_LSB       8
`define ASCS_SRC_LSB       16
`define ASCS_STREAM_BIT    0
`define ASCS_WRITE_BIT     1
`define ASCS_AUTO_BIT      2
`define ASCS_WIDTH_LSB     3
`define ASCS_BLKSZ_LSB     16
`define ASCS_START_BIT     0
`define ASCS_ABORT_BIT     1
`define ASCS_CLK_CTRL_RST  32'h0000_0000
`define ASCS_BLKSZ_RST     16'h0200
`define ASCS_STOP_BYTES    32'h0000_0006
`define ASCS_STOP_BITS     6'h30
`define ASCS_IDLE_CCLK     4'h8
`define ASCS_END_CCLK      2'h2
`define ASCS_RD_THR_1      16'h0004
`define ASCS_RD_THR_4      16'h0010
`define ASCS_RD_THR_8      16'h0020
`define ASCS_WR_THR_1      16'h0003
`define ASCS_WR_THR_4      16'h000C
`define ASCS_WR_THR_8      16'h0018
`endif

// File: ascs_sync.sv
// three-stage synchroniser; the level changes once stages two and three agree
`timescale 1ns/100ps
module ascs_sync (
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic [2:0] s;
        logic       lvl;
    } ascs_sync_t;

    ascs_sync_t r;
    ascs_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.s = {r.s[1:0], d};
        if (r.s[1] == r.s[2]) begin
            next_r.lvl = r.s[2];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.lvl;
endmodule : ascs_sync

// File: ascs_tb.sv
// self-checking bench for the auto-stop and card clock block
`timescale 1ns/100ps
`include "ascs_regs.svh"
module testbench;
    logic        CLK, RST_N, PSEL, PENABLE, PWRITE, FIFO_FULL, FIFO_EMPTY;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd_q, stop_at, nbytes, end_gap, st_gap;
    logic        PREADY, PSLVERR, CMD_IDLE, CARD_IDLE, BYTE_DONE, CRC_DONE, STOP_END;
    logic        DATA_DONE, CCLK_FB, CMD_START, STOP_LOAD, DATA_HOLD, XFER_END, CCLK_OUT;
    logic        rd_e, hold_seen, m_wr, m_st, ran_hi;
    logic [15:0] m_total, m_blk, b;
    logic [7:0]  dv [3] = '{8'h01, 8'h04, 8'hFF};
    logic [15:0] rt [3] = '{16'h0004, 16'h0010, 16'h0020};
    logic [15:0] wt [3] = '{16'h0003, 16'h000C, 16'h0018};
    int          err_total, comparisons, r;

    ascs_top uut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FIFO_FULL(FIFO_FULL), .FIFO_EMPTY(FIFO_EMPTY), .CMD_IDLE(CMD_IDLE),
        .CARD_IDLE(CARD_IDLE), .BYTE_DONE(BYTE_DONE), .CRC_DONE(CRC_DONE),
        .STOP_END(STOP_END), .DATA_DONE(DATA_DONE), .CCLK_FB(CCLK_FB), .CMD_START(CMD_START),
        .STOP_LOAD(STOP_LOAD), .DATA_HOLD(DATA_HOLD), .XFER_END(XFER_END), .CCLK_OUT(CCLK_OUT));
    ascs_card_model card (.CLK(CLK), .RST_N(RST_N), .CCLK_OUT(CCLK_OUT), .CMD_START(CMD_START),
        .STOP_LOAD(STOP_LOAD), .DATA_HOLD(DATA_HOLD), .total(m_total), .blk(m_blk), .wr(m_wr),
        .stream(m_st), .CCLK_FB(CCLK_FB), .CMD_IDLE(CMD_IDLE), .CARD_IDLE(CARD_IDLE),
        .BYTE_DONE(BYTE_DONE), .CRC_DONE(CRC_DONE), .STOP_END(STOP_END), .DATA_DONE(DATA_DONE));

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            err_total++;
            final_report();
        end
        rd_q = PRDATA;
        rd_e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wrr

    task automatic rises(input int cyc, output int cnt);
        logic p;
        p = CCLK_OUT;
        cnt = 0;
        repeat (cyc) begin
            @(posedge CLK);
            if (CCLK_OUT === 1'b1 && p !== 1'b1) cnt++;
            p = CCLK_OUT;
        end
    endtask : rises

    function automatic logic [31:0] cf(input logic [15:0] bl, input logic [1:0] w,
                                       input logic wrt, input logic st);
        return {bl, 11'h000, w, 1'b1, wrt, st};
    endfunction : cf

    task automatic run(input logic [31:0] cfg, input logic [15:0] cnt, input int stall,
                       input int ab);
        int n, se, lb, sl;
        wrr(`ASCS_OFS_XFER_CFG, cfg);
        wrr(`ASCS_OFS_BYTE_CNT, {16'h0000, cnt});
        m_total <= cnt;
        m_blk   <= cfg[31:16];
        m_wr    <= cfg[1];
        m_st    <= cfg[0];
        wrr(`ASCS_OFS_CMD, 32'h0000_0001);
        stop_at = '1;
        end_gap = '1;
        nbytes = 0;
        hold_seen = 1'b0;
        ran_hi = 1'b0;
        se = -1;
        lb = 0;
        sl = 0;
        for (n = 0; n < 6000; n++) begin
            if (n == ab) wrr(`ASCS_OFS_CMD, 32'h0000_0002);
            @(posedge CLK);
            FIFO_FULL  <= stall != 0 && !cfg[1] && n >= 400 && n < 500;
            FIFO_EMPTY <= stall != 0 && cfg[1] && n >= 400 && n < 500;
            if (n > 410 && n < 500 && CCLK_OUT === 1'b1) ran_hi = 1'b1;
            if (BYTE_DONE === 1'b1) begin
                nbytes++;
                lb = n;
            end
            if (STOP_LOAD === 1'b1) begin
                stop_at = nbytes;
                sl = n;
            end
            if (DATA_HOLD === 1'b1) hold_seen = 1'b1;
            if (STOP_END === 1'b1) se = n;
            if (XFER_END === 1'b1) break;
        end
        if (se >= 0) end_gap = n - se;
        st_gap = sl - lb;
        do @(posedge CLK) n++; while (CMD_IDLE !== 1'b1 && n < 6000);
        if (n >= 6000 && ab < 0) begin
            err_total++;
            $display("Error %0t: transfer never ended", $time);
            final_report();
        end
    endtask : run

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    initial begin
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        FIFO_FULL = 1'b0;
        FIFO_EMPTY = 1'b0;
        m_total = 16'h0000;
        m_blk = 16'h0001;
        m_wr = 1'b0;
        m_st = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        apb(1'b0, `ASCS_OFS_CLK_CTRL, 32'h0);
        chk(rd_q, `ASCS_CLK_CTRL_RST);
        apb(1'b0, `ASCS_OFS_XFER_CFG, 32'h0);
        chk(rd_q, {`ASCS_BLKSZ_RST, 16'h0000});
        apb(1'b0, 8'h14, 32'h0);
        chk(rd_e, 1'b1);
        $display("test registers done");
        rises(100, r);
        chk(r, 0);
        for (int i = 0; i < 3; i++) begin
            wrr(`ASCS_OFS_CLK_CTRL, 32'h0);
            wrr(`ASCS_OFS_CLK_CTRL, {16'h0000, dv[i], 8'h00});
            wrr(`ASCS_OFS_CLK_CTRL, {16'h0000, dv[i], 8'h01});
            repeat (10) @(posedge CLK);
            rises(8 * dv[i], r);
            chk(r, 4);
        end
        wrr(`ASCS_OFS_CLK_CTRL, 32'h0);
        wrr(`ASCS_OFS_CLK_CTRL, 32'h1);
        repeat (4) @(posedge CLK);
        #1 chk(CCLK_OUT, 1'b1);
        @(negedge CLK);
        #1 chk(CCLK_OUT, 1'b0);
        wrr(`ASCS_OFS_CLK_CTRL, 32'h0);
        repeat (4) @(posedge CLK);
        #1 chk(CCLK_OUT, 1'b0);
        wrr(`ASCS_OFS_CLK_CTRL, 32'h0000_0400);
        wrr(`ASCS_OFS_CLK_CTRL, 32'h0000_0403);
        repeat (300) @(posedge CLK);
        rises(100, r);
        chk(r, 0);
        apb(1'b0, `ASCS_OFS_STATUS, 32'h0);
        chk(rd_q & 32'h10, 32'h10);
        $display("test clock done");
        run(cf(16'h8, 2'h0, 1'b0, 1'b1), 16'd10, 1, -1);
        chk(stop_at, 4);
        chk(nbytes, 10);
        chk(ran_hi, 1'b0);
        chk(end_gap >= 9 && end_gap <= 24, 1'b1);
        run(cf(16'h8, 2'h0, 1'b0, 1'b1), 16'd3, 0, -1);
        chk(nbytes, 6);
        run(cf(16'h8, 2'h0, 1'b1, 1'b1), 16'd10, 1, -1);
        chk(stop_at, 4);
        chk(nbytes, 10);
        chk(ran_hi, 1'b0);
        run(cf(16'h8, 2'h0, 1'b1, 1'b1), 16'd3, 0, -1);
        chk(hold_seen, 1'b1);
        chk(nbytes, 3);
        for (int w = 0; w < 3; w++) begin
            for (int s = 0; s < 2; s++) begin
                b = rt[w] - 16'(s);
                run(cf(b, 2'(w), 1'b0, 1'b0), 2 * b, 0, -1);
                chk(stop_at, (s != 0) ? 2 * b : b);
                b = wt[w] - 16'(s);
                run(cf(b, 2'(w), 1'b1, 1'b0), 2 * b, 0, -1);
                chk(st_gap > 20, s == 0);
            end
        end
        run(cf(16'h8, 2'h0, 1'b0, 1'b0), 16'd8, 0, -1);
        chk(stop_at, 32'hFFFF_FFFF);
        run(cf(16'h8, 2'h0, 1'b0, 1'b1), 16'd10, 0, 300);
        chk(stop_at, 32'hFFFF_FFFF);
        $display("test transfers done");
        final_report();
    end
endmodule : testbench

// File: ascs_top.sv
// auto-stop placement and card clock control with an APB register port
// Functional notes
// - count equal block length is single block; n times is predefined multi-block
// - stream read auto-stop loaded so end bit meets last byte
// - stream read below six bytes receives a few surplus bytes
// - stream write auto-stop end bit coincides with last byte
// - stream write below six bytes delays data to align with stop end
// - multi-block read: small blocks stop after all bytes, else timed
// - multi-block write: small blocks stop after all blocks, else after CRC status
// - pending stop waits until a loaded command and response finish
// - software stop or abort cancels the automatic stop
// - divider setting zero bypasses, else divides by twice the setting
// - card clock runs only while clock-on bit set
// - low-power gating stops clock after eight idle cycles, restarts on command
// - clock stops on full FIFO reading, empty FIFO writing
// - stream transfer ends two card clocks after stop end bit
// - mode bit one is stream; zero count is open-ended
`timescale 1ns/100ps
`include "ascs_regs.svh"
module ascs_top
    import ascs_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        FIFO_FULL,
    input  wire logic        FIFO_EMPTY,
    input  wire logic        CMD_IDLE,
    input  wire logic        CARD_IDLE,
    input  wire logic        BYTE_DONE,
    input  wire logic        CRC_DONE,
    input  wire logic        STOP_END,
    input  wire logic        DATA_DONE,
    input  wire logic        CCLK_FB,
    output logic             CMD_START,
    output logic             STOP_LOAD,
    output logic             DATA_HOLD,
    output logic             XFER_END,
    output logic             CCLK_OUT
);
    typedef struct packed {
        logic             clk_on;
        logic             low_power;
        logic [7:0]       div;
        logic [1:0]       clksrc;
        logic             stream;
        logic             wr;
        logic             auto_stop;
        ascs_width_t      width;
        logic [15:0]      blksz;
        logic [CNT_W-1:0] bytcnt;
        logic [CNT_W-1:0] remain;
        ascs_phase_t      phase;
        logic             pending;
        logic             cmd_start;
        logic             stop_load;
        logic             xfer_end;
        logic [1:0]       end_cnt;
        logic [3:0]       idle_cnt;
        logic [5:0]       hold_cnt;
        logic             cfb_q;
        logic [31:0]      prdata;
    } ascs_state_t;

    ascs_state_t  r;
    ascs_state_t  next_r;
    ascs_apb_req_t req;
    ascs_path_t   path;
    logic         cfb;
    logic         cclk_rise;
    logic         wr_en;
    logic         mapped;
    logic         start;
    logic         abort;
    logic         stall;
    logic         lp_gate;
    logic         clk_en;
    logic         lead_hit;
    logic [15:0]  rd_thr;
    logic [15:0]  wr_thr;
    logic [CNT_W-1:0] blk_w;

    initial begin
        if (CNT_W < 16 || CNT_W > 32) $error("ascs_top: CNT_W out of range");
    end

    assign req  = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};
    assign path = '{FIFO_FULL, FIFO_EMPTY, CMD_IDLE, CARD_IDLE,
                    BYTE_DONE, CRC_DONE, STOP_END, DATA_DONE};

    ascs_sync u_cfb_sync (
        .CLK   (CLK),
        .RST_N (RST_N),
        .d     (CCLK_FB),
        .q     (cfb)
    );

    assign cclk_rise = cfb & ~r.cfb_q;
    assign wr_en  = req.psel & req.penable & req.pwrite;
    assign mapped = req.paddr inside {`ASCS_OFS_CLK_CTRL, `ASCS_OFS_XFER_CFG,
                                      `ASCS_OFS_BYTE_CNT, `ASCS_OFS_CMD,
                                      `ASCS_OFS_STATUS};
    assign start  = wr_en && req.paddr == `ASCS_OFS_CMD && req.pwdata[`ASCS_START_BIT];
    assign abort  = wr_en && req.paddr == `ASCS_OFS_CMD && req.pwdata[`ASCS_ABORT_BIT];
    assign blk_w  = CNT_W'(r.blksz);

    always_comb begin
        unique case (r.width)
            ASCS_W4: begin
                rd_thr = `ASCS_RD_THR_4;
                wr_thr = `ASCS_WR_THR_4;
            end
            ASCS_W8: begin
                rd_thr = `ASCS_RD_THR_8;
                wr_thr = `ASCS_WR_THR_8;
            end
            default: begin
                rd_thr = `ASCS_RD_THR_1;
                wr_thr = `ASCS_WR_THR_1;
            end
        endcase
    end

    // moment at which the internal stop command may enter the command path
    always_comb begin
        if (r.stream) begin
            lead_hit = r.remain <= CNT_W'(`ASCS_STOP_BYTES);
        end else if (!r.wr) begin
            lead_hit = (r.blksz < rd_thr) ? path.data_done
                                          : (r.remain <= CNT_W'(rd_thr));
        end else begin
            lead_hit = (r.blksz < wr_thr) ? (r.remain == '0)
                                          : (r.remain == '0 && path.crc_done);
        end
    end

    assign stall   = (r.phase == ASCS_RUN) && r.remain != '0 &&
                     ((!r.wr && path.full) || (r.wr && path.empty));
    assign lp_gate = r.low_power && r.idle_cnt >= `ASCS_IDLE_CCLK;
    assign clk_en  = r.clk_on && !lp_gate && !stall;

    always_comb begin
        next_r = r;
        next_r.cfb_q     = cfb;
        next_r.cmd_start = start;
        next_r.stop_load = 1'b0;
        next_r.xfer_end  = 1'b0;
        if (wr_en) begin
            unique case (req.paddr)
                `ASCS_OFS_CLK_CTRL: begin
                    next_r.clk_on    = req.pwdata[`ASCS_CLK_ON_BIT];
                    next_r.low_power = req.pwdata[`ASCS_LOW_PWR_BIT];
                    next_r.div       = req.pwdata[`ASCS_DIV_LSB +: 8];
                    next_r.clksrc    = req.pwdata[`ASCS_SRC_LSB +: 2];
                end
                `ASCS_OFS_XFER_CFG: begin
                    next_r.stream    = req.pwdata[`ASCS_STREAM_BIT];
                    next_r.wr        = req.pwdata[`ASCS_WRITE_BIT];
                    next_r.auto_stop = req.pwdata[`ASCS_AUTO_BIT];
                    next_r.width     = ascs_width_t'(req.pwdata[`ASCS_WIDTH_LSB +: 2]);
                    next_r.blksz     = req.pwdata[`ASCS_BLKSZ_LSB +: 16];
                end
                `ASCS_OFS_BYTE_CNT: next_r.bytcnt = req.pwdata[CNT_W-1:0];
                default: ;
            endcase
        end
        // card clocks seen on the feedback pin
        if (start || !path.cmd_idle || !path.card_idle) begin
            next_r.idle_cnt = '0;
        end else if (cclk_rise && r.idle_cnt < `ASCS_IDLE_CCLK) begin
            next_r.idle_cnt = r.idle_cnt + 4'h1;
        end
        if (cclk_rise && r.hold_cnt != '0 && !r.pending) begin
            next_r.hold_cnt = r.hold_cnt - 6'h01;
        end
        unique case (r.phase)
            ASCS_IDLE: ;
            ASCS_RUN: begin
                if (path.byte_done && r.remain != '0) begin
                    next_r.remain = r.remain - CNT_W'(1);
                end
                if (r.pending && lead_hit && path.cmd_idle & !r.cmd_start & !abort) begin
                    next_r.pending   = 1'b0;
                    next_r.stop_load = 1'b1;
                end
                if (path.stop_end && r.stream) begin
                    next_r.phase   = ASCS_TAIL;
                    next_r.end_cnt = '0;
                end else if (path.data_done && !r.stream) begin
                    next_r.phase    = ASCS_IDLE;
                    next_r.pending  = 1'b0;
                    next_r.xfer_end = 1'b1;
                end
            end
            ASCS_TAIL: begin
                if (cclk_rise) begin
                    next_r.end_cnt = r.end_cnt + 2'h1;
                    if (r.end_cnt + 2'h1 == `ASCS_END_CCLK) begin
                        next_r.phase    = ASCS_IDLE;
                        next_r.xfer_end = 1'b1;
                    end
                end
            end
        endcase
        if (start && !abort) begin
            next_r.phase    = ASCS_RUN;
            next_r.remain   = r.bytcnt;
            // zero count is open-ended; equal to block is single block
            next_r.pending  = r.auto_stop && r.bytcnt != '0 &&
                              (r.stream || r.bytcnt > blk_w);
            next_r.hold_cnt = '0;
            if (r.stream && r.wr && r.auto_stop && r.bytcnt != '0 &&
                r.bytcnt < CNT_W'(`ASCS_STOP_BYTES)) begin
                next_r.hold_cnt = `ASCS_STOP_BITS - 6'(r.bytcnt[2:0]) * 6'h08;
            end
        end
        if (abort) begin
            next_r.pending = 1'b0;
        end
        if (req.psel && !req.penable) begin
            next_r.prdata = '0;
            unique case (req.paddr)
                `ASCS_OFS_CLK_CTRL: next_r.prdata = {14'h0000, r.clksrc, r.div,
                                                     6'h00, r.low_power, r.clk_on};
                `ASCS_OFS_XFER_CFG: next_r.prdata = {r.blksz, 11'h000, r.width,
                                                     r.auto_stop, r.wr, r.stream};
                `ASCS_OFS_BYTE_CNT: next_r.prdata = 32'(r.bytcnt);
                `ASCS_OFS_STATUS:   next_r.prdata = {8'h00, 16'(r.remain), 2'h0,
                                                     r.hold_cnt != '0, lp_gate,
                                                     clk_en, r.phase == ASCS_RUN,
                                                     r.phase == ASCS_TAIL, r.pending};
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r        <= '0;
            r.phase  <= ASCS_IDLE;
            r.blksz  <= `ASCS_BLKSZ_RST;
        end else begin
            r <= next_r;
        end
    end

    ascs_clkdiv #(
        .DIV_W (8)
    ) u_div (
        .CLK   (CLK),
        .RST_N (RST_N),
        .en    (clk_en),
        .div   (r.div),
        .cclk  (CCLK_OUT)
    );

    assign PRDATA    = r.prdata;
    assign PREADY    = 1'b1;
    assign PSLVERR   = req.psel & req.penable & ~mapped;
    assign CMD_START = r.cmd_start;
    assign STOP_LOAD = r.stop_load;
    assign DATA_HOLD = r.hold_cnt != '0;
    assign XFER_END  = r.xfer_end;

    stop_after_cmd_a: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(r.stop_load) |-> $past(path.cmd_idle) && !$past(r.pending, 2) == 1'b0)
        else $error("stop loaded while command path busy");
    abort_cancels_a: assert property (@(posedge CLK) disable iff (!RST_N)
        abort |=> !r.pending && !r.stop_load)
        else $error("automatic stop survived software stop");
    open_no_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (start && !abort && r.bytcnt == '0) |=> !r.pending && r.phase == ASCS_RUN)
        else $error("open-ended transfer armed a stop");
    single_no_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (start && !abort && !r.stream && r.bytcnt == blk_w) |=> !r.pending)
        else $error("single block armed a stop");
    stream_lead_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (r.stop_load && r.stream) |-> $past(r.remain) <= CNT_W'(`ASCS_STOP_BYTES))
        else $error("stream stop loaded too early");
    short_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (start && !abort && r.stream && r.wr && r.auto_stop && r.bytcnt == CNT_W'(3))
        |=> r.hold_cnt == 6'h18 && DATA_HOLD)
        else $error("short stream write not delayed");
    clk_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!r.clk_on [*2]) |-> !u_div.r.ph)
        else $error("card clock running while switched off");
    fifo_stall_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (r.phase == ASCS_RUN && r.remain != '0 && !r.wr && path.full) |-> !clk_en)
        else $error("clock not stopped on full FIFO");
    lp_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (r.low_power && r.idle_cnt == `ASCS_IDLE_CCLK && !start) |-> !clk_en)
        else $error("idle clock not gated");
    tail_two_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (r.xfer_end && $past(r.phase) == ASCS_TAIL) |-> $past(r.end_cnt) == 2'h1)
        else $error("stream ended at wrong card clock");
endmodule : ascs_top
